// ===== verilog/refresh_pkg.sv
package refresh_pkg;

    // Register byte offsets on the AXI4-Lite slave.
    localparam logic [11:0] CTRL_OFFSET = 12'h000;
    localparam logic [11:0] STATUS_OFFSET = 12'h004;
    localparam logic [11:0] COUNT_OFFSET = 12'h008;

    // Field positions inside the control register.
    localparam int WCD_POS = 0;
    localparam int CEC_POS = 1;
    localparam int PIPE_POS = 2;
    localparam int RTYPE_POS = 3;
    localparam int RLOW_POS = 4;
    localparam int RPER_POS = 6;
    localparam int PRECH_POS = 10;
    localparam int CTRL_BITS = 12;

    // Reset value of the control register: every option off.
    localparam logic [11:0] CTRL_RESET = 12'h000;

    // AXI response codes.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // System clock rate and refresh tick rate, both in kHz.
    localparam int CLK_KHZ = 125000;
    localparam int TICK_KHZ = 2000;
    // Tick prescaler; a period rounds down to whole cycles.
    localparam logic [5:0] TICK_CYCLES = 6'(CLK_KHZ / TICK_KHZ);

    // Refresh timer period in ticks is this base plus twice the field.
    localparam logic [5:0] PERIOD_BASE = 6'h10;
    // Refresh RAS low time in cycles is this base plus the field.
    localparam logic [2:0] RAS_LOW_BASE = 3'h2;
    // RAS precharge time in cycles is this base plus the field.
    localparam logic [2:0] PRECH_BASE = 3'h1;

    // Refresh address counter layout: bank, column, row from the top.
    localparam int ROW_W = 11;
    localparam int COL_W = 11;
    localparam int BANK_W = 2;
    localparam int CNT_W = ROW_W + COL_W + BANK_W;
    // Lowest counter bit shown on the high address outputs.
    localparam int HI_ADDR_LSB = 7;

    // Control register fields, high bit first.
    typedef struct packed {
        logic [1:0] prech;
        logic [3:0] period;
        logic [1:0] ras_low;
        logic rtype;
        logic pipe;
        logic cec;
        logic wcd;
    } ctrl_type;

    // Refresh address counter split into its fields.
    typedef struct packed {
        logic [BANK_W-1:0] bank;
        logic [COL_W-1:0] col;
        logic [ROW_W-1:0] row;
    } raddr_type;

    // Arbiter states, one-hot.
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_ACCESS = 4'h2,
        ST_ARM = 4'h4,
        ST_REFRESH = 4'h8
    } state_type;

endpackage : refresh_pkg

// ===== verilog/dram_refresh_ctrl.sv
// Function
// R1 - Write with delay bit: CAS waits one edge.
// R2 - Delay bit clear: read and write CAS alike.
// R3 - One refresh type active, any control mode.
// R4 - Extend input lengthens refresh by whole cycles.
// R5 - Progress flag rises one cycle before RAS.
// R6 - After access hold drops, flag then RAS.
// R7 - Counter increments when refresh RAS negates.
// R8 - Refresh RAS low time from two bits.
// R9 - Timer period from four bits, request each.
// R10 - Refresh only when idle and precharged.
// R11 - Refresh may slot between pipelined accesses.
// R12 - Timer refresh only while disable negated.
// R13 - External pulse latched, refresh next edge.
// R14 - External latch clears as refresh RAS negates.
// R15 - Held external request repeats refresh cycles.
// R16 - High address outputs show counter bits.
// R17 - Write enable pin becomes refresh request.
// R18 - Request rises on external pulse or timer.
// R19 - Timer request held until external pulse.
// R20 - Missed periods toggle the request low.
// R21 - Precharge before, after and between refreshes.
// R22 - All four RAS together, end with flag.
// R23 - Extend sampled each edge, ends when low.
// R24 - Counter is bank, column, row, row low.
// R25 - Refresh beats an access seen same edge.
//
// Local design decisions: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module dram_refresh_ctrl
    import refresh_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic access_request_in,
    input wire logic access_hold_request,
    input wire logic port_b_access_hold,
    input wire logic write_request_in,
    input wire logic [3:0] cas_extend_in,
    input wire logic refresh_extend_in,
    input wire logic external_refresh_request_in,
    input wire logic auto_refresh_disable_in,
    output logic [3:0] ras_n_out,
    output logic [3:0] cas_n_out,
    output logic write_enable_n_out,
    output logic refresh_in_progress_out,
    output logic refresh_request_out,
    output logic access_active_flag,
    output logic [3:0] high_address_outputs
);

    // Maps a byte address to a register index; three means unmapped.
    function automatic logic [1:0] reg_index(input logic [11:0] addr);
        case (addr)
            CTRL_OFFSET: reg_index = 2'h0;
            STATUS_OFFSET: reg_index = 2'h1;
            COUNT_OFFSET: reg_index = 2'h2;
            default: reg_index = 2'h3;
        endcase
    endfunction : reg_index

    ctrl_type ctrl_ff; // Software configuration.
    state_type state_ff; // Arbiter state.
    raddr_type rcount_ff; // Refresh address counter.
    logic [5:0] prescale_ff; // Divider to the refresh tick.
    logic [5:0] period_ff; // Ticks into the refresh period.
    logic timer_req_ff; // Timer request not yet served.
    logic ext_latch_ff; // Latched external request.
    logic refresh_request_out_ff; // Refresh request output.
    logic refresh_in_progress_out_ff; // Refresh in progress.
    logic [3:0] ras_n_ff; // RAS pins.
    logic [3:0] cas_n_ff; // CAS pins.
    logic we_n_ff; // Write enable pin.
    logic [3:0] hi_addr_ff; // High address pins.
    logic [2:0] cnt_ff; // Refresh RAS low cycles left.
    logic [2:0] prech_ff; // Precharge cycles left.
    logic aw_got_ff, w_got_ff; // Write address and data held.
    logic [11:0] awaddr_ff; // Held write address.
    logic [31:0] wdata_ff; // Held write data.
    logic [3:0] wstrb_ff; // Held byte strobes.
    logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic [1:0] bresp_ff, rresp_ff; // Bus responses.
    logic [31:0] rdata_ff; // Read data.

    logic tick, expire, refresh_end, access_end, refresh_due;
    logic prech_ok, access_busy, wr_fire, repurposed;
    logic [5:0] period_len; // Timer period in ticks.
    logic [2:0] ras_low_len; // Refresh RAS low time in cycles.
    logic [2:0] prech_len; // Precharge time in cycles.

    // Divider and period arithmetic, plus the arbiter's inputs.
    always_comb begin
        tick = (prescale_ff == TICK_CYCLES - 6'h1);
        period_len = PERIOD_BASE + {1'b0, ctrl_ff.period, 1'b0}; // see R9
        expire = tick && (period_ff == period_len - 6'h1); // see R9
        ras_low_len = RAS_LOW_BASE + {1'b0, ctrl_ff.ras_low}; // see R8
        prech_len = PRECH_BASE + {1'b0, ctrl_ff.prech};
        refresh_end = (state_ff == ST_REFRESH) && (cnt_ff == 3'h0)
            && !refresh_extend_in; // see R23
        access_end = (state_ff == ST_ACCESS) && !access_hold_request;
        prech_ok = (prech_ff == 3'h0); // see R21
        access_busy = port_b_access_hold; // see R6 R25
        // The input is taken as well as the latch, so that a pulse
        // starts the refresh at the very edge that samples it.
        refresh_due = ext_latch_ff || external_refresh_request_in
            || (timer_req_ff && !auto_refresh_disable_in); // see R12
        repurposed = ctrl_ff.cec || ctrl_ff.pipe; // see R17
        wr_fire = aw_got_ff && w_got_ff && !bvalid_ff;
    end

    // AXI write channels: address and data are taken in either order.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            awaddr_ff <= 12'h000;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
        end else begin
            if (s_axi_awvalid && awready_ff) begin
                aw_got_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
                awready_ff <= 1'b0;
            end else if (wr_fire) begin
                aw_got_ff <= 1'b0;
            end else begin
                awready_ff <= !aw_got_ff;
            end
            if (s_axi_wvalid && wready_ff) begin
                w_got_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
                wready_ff <= 1'b0;
            end else if (wr_fire) begin
                w_got_ff <= 1'b0;
            end else begin
                wready_ff <= !w_got_ff;
            end
        end
    end

    // Register write and write response; status and count are
    // read-only, and an unmapped address answers with a decode error.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff <= CTRL_RESET;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= (reg_index(awaddr_ff) == 2'h3) ? RESP_DECERR
                : RESP_OKAY;
            if (reg_index(awaddr_ff) == 2'h0) begin
                if (wstrb_ff[0]) begin
                    ctrl_ff[7:0] <= wdata_ff[7:0];
                end
                if (wstrb_ff[1]) begin
                    ctrl_ff[CTRL_BITS-1:8] <= wdata_ff[CTRL_BITS-1:8];
                end
            end
        end else if (bvalid_ff && s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // Read channel: one read at a time, data one cycle after address.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= RESP_OKAY;
        end else if (s_axi_arvalid && arready_ff) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rresp_ff <= RESP_OKAY;
            case (reg_index(s_axi_araddr))
                2'h0: rdata_ff <= {20'h00000, ctrl_ff};
                2'h1: rdata_ff <= {26'h0000000, refresh_request_out_ff, timer_req_ff,
                    ext_latch_ff, !ras_n_ff[0], access_active_flag,
                    refresh_in_progress_out_ff};
                2'h2: rdata_ff <= {8'h00, rcount_ff};
                default: begin
                    rdata_ff <= 32'h0000_0000;
                    rresp_ff <= RESP_DECERR;
                end
            endcase
        end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end else if (!rvalid_ff) begin
            arready_ff <= 1'b1;
        end
    end

    // Refresh timer: a fixed tick divider feeds the period counter.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prescale_ff <= 6'h00;
            period_ff <= 6'h00;
        end else begin
            prescale_ff <= tick ? 6'h00 : prescale_ff + 6'h1;
            if (expire) begin
                period_ff <= 6'h00;
            end else if (tick) begin
                period_ff <= period_ff + 6'h1;
            end
        end
    end

    // Pending requests. A new request in the ending cycle wins over the
    // clear, so nothing is lost and a held input bursts.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_req_ff <= 1'b0;
            ext_latch_ff <= 1'b0;
        end else begin
            if (expire) begin
                timer_req_ff <= 1'b1; // see R9
            end else if (refresh_end) begin
                timer_req_ff <= 1'b0;
            end
            if (external_refresh_request_in) begin
                ext_latch_ff <= 1'b1; // see R13 R15
            end else if (refresh_end) begin
                ext_latch_ff <= 1'b0; // see R14
            end
        end
    end

    // Refresh request output. A period that runs out while the last is
    // still unserved drops it for one cycle, so a host can count misses.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            refresh_request_out_ff <= 1'b0;
        end else if (expire && timer_req_ff && !refresh_end) begin
            refresh_request_out_ff <= 1'b0; // see R20
        end else begin
            // Held until a refresh of either kind is done. see R18 R19
            refresh_request_out_ff <= expire || external_refresh_request_in
                || (timer_req_ff && !refresh_end)
                || (ext_latch_ff && !refresh_end);
        end
    end

    // Arbiter and RAS/CAS sequencing. Refresh is checked first in idle,
    // so it wins a tie with a new access, and an access is never cut.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= ST_IDLE;
            refresh_in_progress_out_ff <= 1'b0;
            ras_n_ff <= 4'hF;
            cas_n_ff <= 4'hF;
            cnt_ff <= 3'h0;
            access_active_flag <= 1'b0;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (refresh_due && prech_ok && !access_busy) begin
                        state_ff <= ST_ARM; // see R10 R25 R11
                        refresh_in_progress_out_ff <= 1'b1; // see R5 R6
                    end else if (access_request_in && prech_ok) begin
                        state_ff <= ST_ACCESS;
                        access_active_flag <= 1'b1;
                        ras_n_ff <= 4'h0;
                        // Delayed CAS keeps write data set up to CAS.
                        if (ctrl_ff.wcd && write_request_in) begin
                            cas_n_ff <= 4'hF; // see R1
                        end else begin
                            cas_n_ff <= ~cas_extend_in; // see R2
                        end
                    end
                end
                ST_ACCESS: begin
                    if (access_end) begin
                        state_ff <= ST_IDLE;
                        access_active_flag <= 1'b0;
                        ras_n_ff <= 4'hF;
                        cas_n_ff <= 4'hF;
                    end else begin
                        cas_n_ff <= ~cas_extend_in; // see R1
                    end
                end
                ST_ARM: begin
                    // Only the all-RAS type is carried; the type bit
                    // does not change the cycle shape. see R3 R22
                    state_ff <= ST_REFRESH;
                    ras_n_ff <= 4'h0;
                    cnt_ff <= ras_low_len - 3'h1; // see R8
                end
                ST_REFRESH: begin
                    if (cnt_ff != 3'h0) begin
                        cnt_ff <= cnt_ff - 3'h1;
                    end else if (refresh_end) begin
                        state_ff <= ST_IDLE; // see R4 R23
                        ras_n_ff <= 4'hF; // see R22
                        refresh_in_progress_out_ff <= 1'b0;
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                    refresh_in_progress_out_ff <= 1'b0;
                    ras_n_ff <= 4'hF;
                    cas_n_ff <= 4'hF;
                    access_active_flag <= 1'b0;
                end
            endcase
        end
    end

    // Precharge counter, loaded whenever RAS returns high.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prech_ff <= 3'h0;
        end else if (refresh_end || access_end) begin
            prech_ff <= prech_len - 3'h1; // see R21
        end else if (prech_ff != 3'h0) begin
            prech_ff <= prech_ff - 3'h1;
        end
    end

    // Refresh address counter, stepped as refresh RAS negates.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rcount_ff <= '0;
        end else if (refresh_end) begin
            rcount_ff <= raddr_type'(rcount_ff + 1'b1); // see R7 R24
        end
    end

    // Shared pins: high address bits during refresh, and write enable
    // that turns into the refresh request when so configured.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hi_addr_ff <= 4'h0;
            we_n_ff <= 1'b1;
        end else begin
            hi_addr_ff <= refresh_in_progress_out_ff ? rcount_ff.row[HI_ADDR_LSB +: 4]
                : 4'h0; // see R16
            if (repurposed) begin
                we_n_ff <= !refresh_request_out_ff; // see R17
            end else begin
                we_n_ff <= !((state_ff == ST_ACCESS) && write_request_in
                    && !access_end);
            end
        end
    end

    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign ras_n_out = ras_n_ff;
    assign cas_n_out = cas_n_ff;
    assign write_enable_n_out = we_n_ff;
    assign refresh_in_progress_out = refresh_in_progress_out_ff;
    assign refresh_request_out = refresh_request_out_ff;
    assign high_address_outputs = hi_addr_ff;

    // Helper: cycles that refresh RAS has been low so far.
    logic [7:0] ras_low_seen_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn || state_ff != ST_REFRESH) begin
            ras_low_seen_ff <= 8'h00;
        end else if (ras_low_seen_ff != 8'hFF) begin
            ras_low_seen_ff <= ras_low_seen_ff + 8'h1;
        end
    end

    a_flag_before_ras: assert property ( // see R5
        @(posedge aclk) disable iff (!aresetn)
        $rose(refresh_in_progress_out_ff) |-> ras_n_ff == 4'hF ##1 ras_n_ff == 4'h0)
        else $error("Refresh RAS did not follow the flag by one cycle.");

    a_ras_end_together: assert property ( // see R22
        @(posedge aclk) disable iff (!aresetn)
        $fell(refresh_in_progress_out_ff) |-> ras_n_ff == 4'hF && $past(ras_n_ff) == 4'h0)
        else $error("Refresh RAS and flag did not end together.");

    a_ras_low_time: assert property ( // see R8
        @(posedge aclk) disable iff (!aresetn)
        $fell(refresh_in_progress_out_ff) |-> ras_low_seen_ff >= {5'h00, $past(ras_low_len)})
        else $error("Refresh RAS low time too short.");

    a_counter_step: assert property ( // see R7
        @(posedge aclk) disable iff (!aresetn)
        $fell(refresh_in_progress_out_ff) |-> rcount_ff == raddr_type'($past(rcount_ff) + 1'b1))
        else $error("Refresh counter did not step at refresh end.");

    a_idle_start: assert property ( // see R10
        @(posedge aclk) disable iff (!aresetn)
        $rose(refresh_in_progress_out_ff) |-> $past(prech_ff) == 3'h0
            && !$past(access_busy) && !access_active_flag)
        else $error("Refresh started during access or precharge.");

    a_precharge_gap: assert property ( // see R21
        @(posedge aclk) disable iff (!aresetn)
        $fell(ras_n_ff[0]) |-> $past(prech_ff) == 3'h0)
        else $error("RAS precharge was not kept.");

    a_latch_clear: assert property ( // see R14
        @(posedge aclk) disable iff (!aresetn)
        $fell(refresh_in_progress_out_ff) |-> ext_latch_ff == $past(external_refresh_request_in))
        else $error("External latch not cleared at refresh end.");

    a_refresh_wins: assert property ( // see R25
        @(posedge aclk) disable iff (!aresetn)
        state_ff == ST_IDLE && refresh_due && prech_ok && !access_busy
            && access_request_in |=> state_ff == ST_ARM)
        else $error("Access won over a refresh.");

    a_write_cas_delay: assert property ( // see R1
        @(posedge aclk) disable iff (!aresetn)
        state_ff == ST_IDLE && !(refresh_due && !access_busy) && prech_ok
            && access_request_in && ctrl_ff.wcd && write_request_in
            |=> cas_n_ff == 4'hF && ras_n_ff == 4'h0)
        else $error("Write CAS was not delayed.");

    a_auto_disabled: assert property ( // see R12
        @(posedge aclk) disable iff (!aresetn)
        state_ff == ST_IDLE && auto_refresh_disable_in && !ext_latch_ff
            && !external_refresh_request_in |=> !refresh_in_progress_out_ff)
        else $error("Timer refresh ran while disabled.");

endmodule : dram_refresh_ctrl

// ===== verification/dram_array_model.sv
`timescale 1ns/1ps
// Array side: watches the RAS and CAS lanes and measures refresh pulses.
module dram_array_model (
    input wire logic aclk,
    input wire logic [3:0] ras_n_out,
    input wire logic [3:0] cas_n_out,
    output int n_refresh,
    output int low_len,
    output int high_len
);
    logic [3:0] prev_ff = 4'hF; // Lanes seen at the last edge.
    logic cas_ff = 1'h0; // A CAS fell in this RAS phase, so no refresh.
    int run_ff = 0; // Edges spent at the current RAS level.
    // Only an all-lane pulse without CAS counts, since an access may
    // also pull every lane low.
    always @(posedge aclk) begin
        prev_ff <= ras_n_out;
        run_ff <= (ras_n_out == prev_ff) ? run_ff + 1 : 1;
        cas_ff <= (ras_n_out == 4'hF) ? 1'h0 : cas_ff | (cas_n_out != 4'hF);
        if (prev_ff == 4'h0 && ras_n_out == 4'hF && !cas_ff) begin
            n_refresh <= n_refresh + 1;
            low_len <= run_ff;
        end
        if (prev_ff == 4'hF && ras_n_out != 4'hF) high_len <= run_ff;
    end
endmodule : dram_array_model

// ===== verification/tb_dram_refresh_and_write_cas_timing.sv
`timescale 1ns/1ps
// Drives host and register bus, checks refresh and CAS timing.
module tb_dram_refresh_and_write_cas_timing
    import refresh_pkg::*;
;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, q;
    logic [3:0] s_axi_wstrb = 4'hF, cas_extend_in = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, write_enable_n_out, refresh_in_progress_out;
    logic refresh_request_out, access_active_flag;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic access_request_in = 1'h0, access_hold_request = 1'h0;
    logic port_b_access_hold = 1'h0, write_request_in = 1'h0;
    logic refresh_extend_in = 1'h0, external_refresh_request_in = 1'h0;
    logic auto_refresh_disable_in = 1'h1;
    logic [3:0] ras_n_out, cas_n_out, high_address_outputs;
    integer seed;
    int errors = 0, n_compared = 0, n_ref, low_len, high_len, n0, rl;
    ctrl_type ctl;
    dram_refresh_ctrl u_dut (.*);
    dram_array_model u_mem (.aclk(aclk), .ras_n_out(ras_n_out),
        .cas_n_out(cas_n_out), .n_refresh(n_ref), .low_len(low_len),
        .high_len(high_len));
    initial forever #4 aclk = ~aclk;
    // Cut a hang short; the sequence needs about a seventh of this span.
    initial begin
        repeat (20000) @(posedge aclk);
        errors++;
        test_done();
    end
    function automatic int exp_low(input ctrl_type c);
        return int'(RAS_LOW_BASE) + int'(c.ras_low);
    endfunction : exp_low
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    // One bus cycle; each valid drops at its own ready, answer in q and r.
    task automatic axi(input logic w, input logic [11:0] a,
            input logic [31:0] d);
        logic done;
        done = 1'h0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_bready <= w;
        s_axi_arvalid <= !w;
        s_axi_rready <= !w;
        while (!done) begin
            @(posedge aclk);
            if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
            if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
            if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
            if (s_axi_bvalid === 1'h1 && w
                    || s_axi_rvalid === 1'h1 && !w) begin
                q = s_axi_rdata;
                r = w ? s_axi_bresp : s_axi_rresp;
                s_axi_bready <= 1'h0;
                s_axi_rready <= 1'h0;
                done = 1'h1;
            end
        end
    endtask : axi
    task automatic wait_flag(input logic v);
        do @(posedge aclk); while (refresh_in_progress_out !== v);
    endtask : wait_flag
    // Raise a host input for one cycle.
    task automatic pulse_ext();
        @(posedge aclk);
        external_refresh_request_in <= 1'h1;
        @(posedge aclk);
        external_refresh_request_in <= 1'h0;
    endtask : pulse_ext
    task automatic test_done();
        if (errors == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : test_done
    initial begin
        seed = 32'h1AC3;
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        axi(1'h0, CTRL_OFFSET, '0);
        check(q, 32'(CTRL_RESET));
        axi(1'h0, 12'h00C, '0);
        check(r, RESP_DECERR);
        axi(1'h1, COUNT_OFFSET, 32'hFFFF);
        check(r, RESP_OKAY);
        axi(1'h0, COUNT_OFFSET, '0);
        check(q, '0);
        // Bit 0 picks CAS delay, bit 1 picks an extended refresh.
        for (int k = 0; k < 4; k++) begin
            ctl = ctrl_type'($random(seed));
            ctl.period = 4'h0;
            ctl.rtype = 1'h0;
            ctl.pipe = k[1];
            ctl.cec = !k[1];
            ctl.wcd = k[0];
            if (k == 0) ctl.ras_low = 2'h3;
            rl = exp_low(ctl);
            axi(1'h1, CTRL_OFFSET, 32'(ctl));
            axi(1'h0, CTRL_OFFSET, '0);
            check(q, 32'(ctl));
            n0 = n_ref;
            refresh_extend_in <= k[1];
            cas_extend_in <= 4'($random(seed)) | 4'h1;
            pulse_ext();
            wait_flag(1'h1);
            check(ras_n_out, 4'hF);
            @(posedge aclk);
            check(ras_n_out, 4'h0);
            repeat (rl + 2) @(posedge aclk);
            refresh_extend_in <= 1'h0;
            wait_flag(1'h0);
            check(ras_n_out, 4'hF);
            @(posedge aclk);
            if (k[1]) check(low_len > rl, 1'h1);
            else check(low_len, rl);
            check(n_ref - n0, 1);
            axi(1'h0, COUNT_OFFSET, '0);
            check(q, n_ref);
            axi(1'h0, STATUS_OFFSET, '0);
            check(q[3], 1'h0);
            // A held request gives a burst spaced by precharge.
            n0 = n_ref;
            external_refresh_request_in <= 1'h1;
            while (n_ref < n0 + 3) @(posedge aclk);
            external_refresh_request_in <= 1'h0;
            repeat (30) @(posedge aclk);
            check(high_len >= PRECH_BASE + ctl.prech, 1'h1);
            // Access and refresh seen together: the refresh goes first.
            access_request_in <= 1'h1;
            access_hold_request <= 1'h1;
            write_request_in <= 1'h1;
            external_refresh_request_in <= 1'h1;
            pulse_ext();
            wait_flag(1'h1);
            check(access_active_flag, 1'h0);
            wait_flag(1'h0);
            do @(posedge aclk); while (ras_n_out === 4'hF);
            access_request_in <= 1'h0;
            check(cas_n_out, ctl.wcd ? 4'hF : 4'(~cas_extend_in));
            @(posedge aclk);
            check(cas_n_out, 4'(~cas_extend_in));
            pulse_ext();
            repeat (8) @(posedge aclk);
            check(refresh_in_progress_out, 1'h0);
            access_hold_request <= 1'h0;
            write_request_in <= 1'h0;
            wait_flag(1'h1);
            wait_flag(1'h0);
            repeat (30) @(posedge aclk);
        end
        // The timer must only ask while disabled, then refresh by itself.
        n0 = (int'(PERIOD_BASE) + 2 * ctl.period) * int'(TICK_CYCLES) + 100;
        rl = n_ref;
        repeat (n0) @(posedge aclk);
        check(n_ref, rl);
        check(refresh_request_out, 1'h1);
        check(write_enable_n_out, 1'h0);
        check(high_address_outputs, 4'h0);
        auto_refresh_disable_in <= 1'h0;
        repeat (n0) @(posedge aclk);
        check(n_ref >= rl + 2, 1'h1);
        test_done();
    end
endmodule : tb_dram_refresh_and_write_cas_timing
